// [rtl/ulpi_alt_regs.svh]
// constants for the ulpi alternate-mode link and phy ends
`ifndef ULPI_ALT_REGS_SVH
`define ULPI_ALT_REGS_SVH
// ****************************************
// phy register addresses (6-bit)
// ****************************************
`define ULPI_FUNC_CTRL 6'h04
`define ULPI_IFC_CTRL 6'h07
`define ULPI_IE_RISE 6'h0D
`define ULPI_IE_FALL 6'h10
`define ULPI_CARKIT_CTRL 6'h19
`define ULPI_CARKIT_IE 6'h1D
// ****************************************
// phy reset values and field positions
// ****************************************
`define ULPI_FUNC_RST 8'h41
`define ULPI_IFC_RST 8'h00
`define ULPI_IE_RST 8'h1F
`define ULPI_CARKIT_RST 8'h00
`define FC_SPEED_LSB 0
`define FC_SUSPEND 6
`define IFC_SER6 0
`define IFC_SER3 1
`define IFC_UART 2
`define IFC_KEEP_CLK 3
`define IFC_PULLUP_DIS 7
`define CK_TX_ROUTE 2
`define CK_RX_ROUTE 3
`define CKIE_FLOAT_RISE 0
`define CKIE_FLOAT_FALL 1
`define INT_VBUS 1
`define INT_SESS_END 3
`define INT_SRC_W 5
// ****************************************
// bus command coding
// ****************************************
`define CMD_REGW 2'b10
`define BUS_IDLE 8'h00
`define OE_ALL_OFF 8'hFF
`define OE_ALL_ON 8'h00
`define OE_SER_TX 8'h07
`define OE_SER_RX 8'h01
// ****************************************
// timing
// ****************************************
`define CLK_MHZ 250
`define CLKOUT_DIV 3'h4
`define ENTER_EDGES 3'h5
`define T_START_NS 200
`define T_START_CYC ((`T_START_NS * `CLK_MHZ + 999) / 1000)
// ****************************************
// link control register map
// ****************************************
`define LNK_CTRL 4'h0
`define LNK_CMD 4'h1
`define LNK_STAT 4'h2
`define LNK_ALT 4'h3
`define LC_READY 0
`define LC_EXIT 1
`endif

// [rtl/ulpi_alt_pkg.sv]
// types shared by the ulpi alternate-mode ends
package ulpi_alt_pkg;
	typedef enum logic [2:0] {ST_SYNC, ST_ENTER, ST_LOWPWR, ST_SER3, ST_SER6, ST_UART, ST_WAKE, ST_RESUME} phy_state_t;
	typedef enum logic [2:0] {LK_BOOT, LK_IDLE, LK_CMD, LK_DATA, LK_ALT, LK_EXIT} link_state_t;
endpackage

// [rtl/ulpi_if.sv]
// ulpi bus carrier with pin resolution
`timescale 1ns/1ps
interface ulpi_if;
	logic dir;
	logic nxt;
	logic stp_link;
	logic stp_link_oe_n;
	logic stp_pullup_en;
	logic [7:0] data_phy;
	logic [7:0] data_phy_oe_n;
	logic [7:0] data_link;
	logic [7:0] data_link_oe_n;
	logic stp;
	logic [7:0] data;
	// a floating stop line follows the phy pull-up, a floating data bit the weak pull-downs
	assign stp = !stp_link_oe_n ? stp_link : stp_pullup_en;
	assign data = (~data_phy_oe_n & data_phy) | (~data_link_oe_n & data_phy_oe_n & data_link);
	modport phy (input stp, data, output dir, nxt, data_phy, data_phy_oe_n, stp_pullup_en);
	modport link (input dir, nxt, data, output stp_link, stp_link_oe_n, data_link, data_link_oe_n);
endinterface // ulpi_if

// [rtl/ulpi_phy_end.sv]
// phy end: start-up protection, low power, serial and uart alternate modes
// Functional notes
// - link holds stop high until ready
// - link drives idle after each turnaround
// - non-idle bus is transmit until stop
// - link resets with stop high, bus released
// - stop pull-up on until disable bit set
// - pull-up off while hardware reset low
// - stop high wakes phy from low power
// - comparators off only if both enables clear
// - link clears float enables, re-enables comparators
// - link writes one serial mode bit; the bench's last entry writes 8'h07, setting all three mode bits
// - dir high, five clocks, then remap bus
// - clock stops in alt modes unless kept
// - interrupt flags level differing from entry sample
// - stop exits; dir drops; stop low resumes
// - hardware reset pulse returns synchronous mode
// - three-pin serial pin mapping
// - six-pin serial pin mapping
// - link sets uart routes before uart bit
// - uart pin mapping with route enables
// - uart edge rate follows speed select
// - no line state in uart mode
// - early stop drop is false resume
`timescale 1ns/1ps
`include "ulpi_alt_regs.svh"
module ulpi_phy_end (
	input wire logic CLK_I,
	input wire logic RST_N_I,
	ulpi_if.phy U,
	input wire logic HW_RESET_N_I,
	input wire logic LINE_DP_I,
	input wire logic LINE_DM_I,
	input wire logic LINE_DIFF_I,
	input wire logic [`INT_SRC_W-1:0] INT_SRC_I,
	output logic USB_TX_EN_O,
	output logic USB_TX_DATA_O,
	output logic USB_SERIAL_TX_SINGLE_ZERO_O,
	output logic UART_TXD_O,
	output logic UART_TXD_EN_O,
	output logic USB_FS_EDGE_O,
	output logic CLKOUT_RUN_O,
	output logic CLKOUT_EN_O,
	output logic [1:0] CMP_POWER_O,
	output ulpi_alt_pkg::phy_state_t MODE_O
);
	import ulpi_alt_pkg::*;

	// ****************************************
	// functions
	// ****************************************
	// six-pin over three-pin over uart, so pin maps never mix
	function automatic phy_state_t alt_pick(input logic [7:0] v);
		if (v[`IFC_SER6]) begin
			alt_pick = ST_SER6;
		end else if (v[`IFC_SER3]) begin
			alt_pick = ST_SER3;
		end else begin
			alt_pick = ST_UART;
		end
	endfunction

	function automatic logic alt_any(input logic [7:0] v);
		alt_any = v[`IFC_SER6] | v[`IFC_SER3] | v[`IFC_UART];
	endfunction

	// ****************************************
	// input synchronisers
	// ****************************************
	localparam int SW = `INT_SRC_W + 4;
	logic [SW-1:0] sync1_q;
	logic [SW-1:0] sync2_q;
	always_ff @(posedge CLK_I) begin
		sync1_q <= {HW_RESET_N_I, LINE_DIFF_I, LINE_DM_I, LINE_DP_I, INT_SRC_I};
		sync2_q <= sync1_q;
	end
	wire logic [`INT_SRC_W-1:0] int_live = sync2_q[`INT_SRC_W-1:0];
	wire logic dp = sync2_q[`INT_SRC_W];
	wire logic dm = sync2_q[`INT_SRC_W+1];
	wire logic diff = sync2_q[`INT_SRC_W+2];
	wire logic hw_n = sync2_q[`INT_SRC_W+3];
	wire logic rst = !RST_N_I || !hw_n;

	// ****************************************
	// state and registers
	// ****************************************
	phy_state_t state_q, ret_q, tgt_q;
	logic [7:0] fc_q, ifc_q, ier_q, ief_q, ck_q, ckie_q;
	logic [1:0] rw_ph_q;
	logic [5:0] rw_addr_q;
	logic dir_q, nxt_q, tx_q, int_q, pullup_q, clk_run_q;
	logic [2:0] div_q, edge_q;
	logic [15:0] wait_q;
	logic [`INT_SRC_W-1:0] smp_q;
	logic [7:0] dout_q, oe_n_q;

	wire logic [7:0] din = U.data;
	wire logic clk_tick = clk_run_q && (div_q == `CLKOUT_DIV - 3'h1);
	wire logic is_cmd = (din != `BUS_IDLE) && (din[7:6] == `CMD_REGW);
	wire logic rw_fire = (state_q == ST_SYNC) && (rw_ph_q == 2'h2);
	wire logic [7:0] ie_any = ier_q | ief_q;
	wire logic int_now = |(ie_any[`INT_SRC_W-1:0] & (int_live ^ smp_q));
	wire logic se0 = !dp && !dm;
	wire logic ser_tx = din[0];
	wire logic start_done = (wait_q == 16'(`T_START_CYC));

	// ****************************************
	// mode sequencer
	// ****************************************
	always_ff @(posedge CLK_I) begin
		if (rst) begin
			state_q <= ST_WAKE;
			ret_q <= ST_SYNC;
			tgt_q <= ST_LOWPWR;
			fc_q <= `ULPI_FUNC_RST;
			ifc_q <= `ULPI_IFC_RST;
			ier_q <= `ULPI_IE_RST;
			ief_q <= `ULPI_IE_RST;
			ck_q <= `ULPI_CARKIT_RST;
			ckie_q <= `ULPI_CARKIT_RST;
			rw_ph_q <= 2'h0;
			rw_addr_q <= 6'h00;
			dir_q <= 1'b1;
			nxt_q <= 1'b0;
			tx_q <= 1'b0;
			clk_run_q <= 1'b1;
			div_q <= 3'h0;
			edge_q <= 3'h0;
			wait_q <= 16'h0000;
			smp_q <= '0;
		end else begin
			div_q <= clk_tick ? 3'h0 : div_q + 3'h1;
			case (state_q)
				ST_SYNC: begin
					if (U.stp) begin
						tx_q <= 1'b0;
					end
					case (rw_ph_q)
						2'h0: begin
							if (is_cmd) begin
								rw_addr_q <= din[5:0];
								nxt_q <= 1'b1;
								rw_ph_q <= 2'h1;
							end else if (din != `BUS_IDLE && !U.stp) begin
								tx_q <= 1'b1;
							end
						end
						2'h1: begin
							nxt_q <= 1'b0;
							rw_ph_q <= 2'h2;
						end
						default: begin
							rw_ph_q <= 2'h0;
						end
					endcase
					if (rw_fire) begin
						case (rw_addr_q)
							`ULPI_FUNC_CTRL: fc_q <= din;
							`ULPI_IFC_CTRL: ifc_q <= din;
							`ULPI_IE_RISE: ier_q <= din;
							`ULPI_IE_FALL: ief_q <= din;
							`ULPI_CARKIT_CTRL: ck_q <= din;
							`ULPI_CARKIT_IE: ckie_q <= din;
							default: ;
						endcase
						if (rw_addr_q == `ULPI_IFC_CTRL && alt_any(din)) begin
							tgt_q <= alt_pick(din);
							state_q <= ST_ENTER;
							dir_q <= 1'b1;
							smp_q <= int_live;
							edge_q <= 3'h0;
						end else if (rw_addr_q == `ULPI_FUNC_CTRL && !din[`FC_SUSPEND]) begin
							tgt_q <= ST_LOWPWR;
							state_q <= ST_ENTER;
							dir_q <= 1'b1;
							smp_q <= int_live;
							edge_q <= 3'h0;
						end
					end
				end
				ST_ENTER: begin
					tx_q <= 1'b0;
					if (clk_tick) begin
						edge_q <= edge_q + 3'h1;
					end
					if (edge_q == `ENTER_EDGES) begin
						state_q <= tgt_q;
						clk_run_q <= ifc_q[`IFC_KEEP_CLK] && (tgt_q != ST_LOWPWR);
					end
				end
				ST_WAKE: begin
					wait_q <= wait_q + 16'h0001;
					if (ret_q != ST_SYNC && !U.stp) begin
						state_q <= ret_q;
						clk_run_q <= ifc_q[`IFC_KEEP_CLK] && (ret_q != ST_LOWPWR);
					end else if (start_done) begin
						dir_q <= 1'b0;
						state_q <= ST_RESUME;
					end
				end
				ST_RESUME: begin
					// stays here while the link still holds stop, so a slow link start is safe
					if (!U.stp) begin
						state_q <= ST_SYNC;
						fc_q[`FC_SUSPEND] <= 1'b1;
						ifc_q[`IFC_UART:`IFC_SER6] <= 3'h0;
						ret_q <= ST_SYNC;
					end
				end
				default: begin
					// low power and all alt modes leave the same way
					if (U.stp) begin
						ret_q <= state_q;
						state_q <= ST_WAKE;
						clk_run_q <= 1'b1;
						wait_q <= 16'h0000;
					end
				end
			endcase
		end
	end

	// ****************************************
	// bus pin mapping
	// ****************************************
	logic [7:0] dnx, oenx;
	always_comb begin
		dnx = `BUS_IDLE;
		oenx = `OE_ALL_ON;
		case (state_q)
			ST_SYNC, ST_RESUME: begin
				oenx = `OE_ALL_OFF;
			end
			ST_LOWPWR: begin
				dnx = {4'h0, int_q, 1'b0, dm, dp};
			end
			ST_SER3: begin
				oenx = ser_tx ? `OE_SER_TX : `OE_SER_RX;
				dnx = {4'h0, int_q, !se0, diff, 1'b0};
			end
			ST_SER6: begin
				oenx = `OE_SER_TX;
				dnx = {1'b0, diff, dm, dp, int_q, 3'h0};
			end
			ST_UART: begin
				oenx = `OE_SER_RX;
				dnx = {4'h0, int_q, 1'b0, ck_q[`CK_RX_ROUTE] & dp, 1'b0};
			end
			default: ;
		endcase
	end

	// ****************************************
	// output registers
	// ****************************************
	wire logic ser_mode = (state_q == ST_SER3) || (state_q == ST_SER6);
	always_ff @(posedge CLK_I) begin
		if (rst) begin
			pullup_q <= 1'b0;
			int_q <= 1'b0;
			dout_q <= `BUS_IDLE;
			oe_n_q <= `OE_ALL_ON;
			USB_TX_EN_O <= 1'b0;
			USB_TX_DATA_O <= 1'b0;
			USB_SERIAL_TX_SINGLE_ZERO_O <= 1'b0;
			UART_TXD_O <= 1'b1;
			UART_TXD_EN_O <= 1'b0;
			USB_FS_EDGE_O <= 1'b1;
			CLKOUT_EN_O <= 1'b0;
			CMP_POWER_O <= 2'h3;
			MODE_O <= ST_WAKE;
		end else begin
			pullup_q <= !ifc_q[`IFC_PULLUP_DIS];
			int_q <= int_now;
			dout_q <= dnx;
			oe_n_q <= oenx;
			USB_TX_EN_O <= ser_mode ? ser_tx : tx_q;
			USB_TX_DATA_O <= ser_mode && din[1];
			USB_SERIAL_TX_SINGLE_ZERO_O <= ser_mode && din[2];
			UART_TXD_EN_O <= (state_q == ST_UART) && ck_q[`CK_TX_ROUTE];
			UART_TXD_O <= !((state_q == ST_UART) && ck_q[`CK_TX_ROUTE]) || din[0];
			USB_FS_EDGE_O <= (fc_q[`FC_SPEED_LSB+1:`FC_SPEED_LSB] != 2'h2);
			CLKOUT_EN_O <= clk_tick;
			CMP_POWER_O <= {ie_any[`INT_SESS_END], ie_any[`INT_VBUS]};
			MODE_O <= state_q;
		end
	end

	assign U.dir = dir_q;
	assign U.nxt = nxt_q;
	assign U.data_phy = dout_q;
	assign U.data_phy_oe_n = oe_n_q;
	assign U.stp_pullup_en = pullup_q;
	assign CLKOUT_RUN_O = clk_run_q;
endmodule // ulpi_phy_end

// [rtl/ulpi_link_end.sv]
// link end: stop and idle handling, register writes, alt-mode pin drive
`timescale 1ns/1ps
`include "ulpi_alt_regs.svh"
module ulpi_link_end (
	input wire logic CLK_I,
	input wire logic RST_N_I,
	ulpi_if.link U,
	input wire logic [3:0] ADDR_I,
	input wire logic [15:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [15:0] RDATA_O
);
	import ulpi_alt_pkg::*;

	// ****************************************
	// control registers
	// ****************************************
	link_state_t state_q;
	logic ready_q, exit_q, pend_q, stp_q;
	logic [13:0] cmd_q;
	logic [7:0] alt_q, alt_oe_n_q, dout_q, oe_n_q;
	wire logic wr_ctrl = WR_I && (ADDR_I == `LNK_CTRL);
	wire logic wr_cmd = WR_I && (ADDR_I == `LNK_CMD);
	wire logic wr_alt = WR_I && (ADDR_I == `LNK_ALT);
	wire logic [15:0] stat = {4'h0, pend_q, 1'(state_q == LK_ALT), U.nxt, U.dir, U.data};
	wire logic [15:0] rd_mux = (ADDR_I == `LNK_CTRL) ? {14'h0000, exit_q, ready_q} :
		(ADDR_I == `LNK_CMD) ? {2'h0, cmd_q} :
		(ADDR_I == `LNK_STAT) ? stat :
		(ADDR_I == `LNK_ALT) ? {alt_oe_n_q, alt_q} : 16'h0000;

	// ****************************************
	// sequencer
	// ****************************************
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			state_q <= LK_BOOT;
			ready_q <= 1'b0;
			exit_q <= 1'b0;
			pend_q <= 1'b0;
			cmd_q <= 14'h0000;
			alt_q <= `BUS_IDLE;
			alt_oe_n_q <= `OE_ALL_OFF;
			stp_q <= 1'b1;
			dout_q <= `BUS_IDLE;
			oe_n_q <= `OE_ALL_OFF;
			RDATA_O <= 16'h0000;
		end else begin
			RDATA_O <= RD_I ? rd_mux : 16'h0000;
			if (wr_ctrl) begin
				ready_q <= WDATA_I[`LC_READY];
				exit_q <= WDATA_I[`LC_EXIT];
			end
			// a new command written while one is pending replaces it
			if (wr_cmd) begin
				cmd_q <= WDATA_I[13:0];
				pend_q <= 1'b1;
			end
			if (wr_alt) begin
				alt_q <= WDATA_I[7:0];
				alt_oe_n_q <= WDATA_I[15:8];
			end
			case (state_q)
				LK_BOOT: begin
					stp_q <= 1'b1;
					if (ready_q) begin
						state_q <= LK_EXIT;
					end
				end
				LK_IDLE: begin
					stp_q <= 1'b0;
					oe_n_q <= U.dir ? `OE_ALL_OFF : `OE_ALL_ON;
					dout_q <= `BUS_IDLE;
					if (U.dir) begin
						state_q <= LK_ALT;
					end else if (pend_q && !wr_cmd) begin
						dout_q <= {`CMD_REGW, cmd_q[13:8]};
						state_q <= LK_CMD;
					end
				end
				LK_CMD: begin
					if (U.nxt) begin
						dout_q <= cmd_q[7:0];
						state_q <= LK_DATA;
					end
				end
				LK_DATA: begin
					dout_q <= `BUS_IDLE;
					pend_q <= wr_cmd;
					state_q <= LK_IDLE;
				end
				LK_ALT: begin
					dout_q <= alt_q;
					oe_n_q <= alt_oe_n_q;
					if (exit_q) begin
						exit_q <= 1'b0;
						stp_q <= 1'b1;
						state_q <= LK_EXIT;
					end else if (!U.dir) begin
						oe_n_q <= `OE_ALL_ON;
						dout_q <= `BUS_IDLE;
						state_q <= LK_IDLE;
					end
				end
				default: begin
					oe_n_q <= `OE_ALL_OFF;
					if (!U.dir) begin
						stp_q <= 1'b0;
						oe_n_q <= `OE_ALL_ON;
						dout_q <= `BUS_IDLE;
						state_q <= LK_IDLE;
					end
				end
			endcase
		end
	end

	assign U.stp_link = stp_q;
	assign U.stp_link_oe_n = 1'b0;
	assign U.data_link = dout_q;
	assign U.data_link_oe_n = oe_n_q;
endmodule // ulpi_link_end

// [tb/ulpi_alt_mode_interface_sva.sv]
// checker watching the ulpi carrier between the link and phy ends
`timescale 1ns/1ps
module ulpi_alt_mode_interface_sva (
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic dir,
	input wire logic nxt,
	input wire logic stp,
	input wire logic stp_link_oe_n,
	input wire logic stp_pullup_en,
	input wire logic [7:0] data,
	input wire logic [7:0] data_link_oe_n
);
	// ****************************************
	// carrier assertions
	// ****************************************
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	link_reset_park_a: assert property (disable iff (1'b0) !RST_N_I |=> stp && !stp_link_oe_n && data_link_oe_n == 8'hFF)
		else $error("link not parked during reset");
	pullup_reset_off_a: assert property (disable iff (1'b0) !RST_N_I |=> !stp_pullup_en)
		else $error("stop pull-up on during reset");
	pullup_power_on_a: assert property ($rose(RST_N_I) |=> stp_pullup_en)
		else $error("stop pull-up not on after reset");
	release_needs_stop_a: assert property ($fell(dir) |-> stp)
		else $error("dir dropped without stop high");
	idle_after_turn_a: assert property ($fell(dir) |-> ##1 data == 8'h00)
		else $error("bus not idle after turnaround");
	entry_after_cmd_a: assert property ($rose(dir) |-> $past(nxt, 2) || $past(nxt, 3) || $past(nxt, 4))
		else $error("dir raised without a register write");
	entry_dir_hold_a: assert property ($rose(dir) |-> dir [*8])
		else $error("dir dropped during mode entry");
	false_resume_a: assert property (dir && $fell(stp) |-> dir [*6])
		else $error("early stop drop released the bus");
	cmd_handshake_a: assert property ($rose(nxt) |-> !dir && $past(data[7:6]) == 2'b10 ##1 !nxt)
		else $error("nxt without a write command");
	entry_c: cover property ($rose(dir));
	exit_c: cover property ($fell(dir));
	cmd_c: cover property ($rose(nxt));
endmodule // ulpi_alt_mode_interface_sva

// [tb/ulpi_alt_mode_interface_tb_top.sv]
// bench joining both ulpi ends and driving the link register port
`timescale 1ns/1ps
`include "ulpi_alt_regs.svh"
module ulpi_alt_mode_interface_tb_top;
	import ulpi_alt_pkg::*;
	typedef struct packed {logic [5:0] a; logic [7:0] d; logic [15:0] alt; phy_state_t m; logic keep; logic hw;} entry_t;
	// low power write also selects low speed, which the uart entry relies on
	localparam entry_t TBL [5] = '{
		'{`ULPI_FUNC_CTRL, 8'h02, 16'hFF00, ST_LOWPWR, 1'b0, 1'b0},
		'{`ULPI_IFC_CTRL, 8'h01, 16'hF805, ST_SER6, 1'b0, 1'b0},
		'{`ULPI_IFC_CTRL, 8'h0C, 16'hFE00, ST_UART, 1'b1, 1'b0},
		'{`ULPI_IFC_CTRL, 8'h0A, 16'hFE00, ST_SER3, 1'b1, 1'b0},
		'{`ULPI_IFC_CTRL, 8'h07, 16'hF805, ST_SER6, 1'b0, 1'b1}};
	logic clk, rst_n, hw_rst_n, dp, dm, diff, wr, rd, tx_en, tx_data, serial_tx_single_zero, txd, fs_edge, clk_run, txd_en, clk_en;
	logic [4:0] int_src;
	logic [3:0] addr;
	logic [15:0] wdata, rdata, v;
	logic [1:0] cmp_pwr;
	phy_state_t mode;
	int fail_count, n_compared;
	int n_tick;
	ulpi_if u ();
	ulpi_phy_end ulpi_phy_end_i (.CLK_I(clk), .RST_N_I(rst_n), .U(u.phy), .HW_RESET_N_I(hw_rst_n), .LINE_DP_I(dp),
		.LINE_DM_I(dm), .LINE_DIFF_I(diff), .INT_SRC_I(int_src), .USB_TX_EN_O(tx_en), .USB_TX_DATA_O(tx_data),
		.USB_SERIAL_TX_SINGLE_ZERO_O(serial_tx_single_zero), .UART_TXD_O(txd), .UART_TXD_EN_O(txd_en), .USB_FS_EDGE_O(fs_edge),
		.CLKOUT_RUN_O(clk_run), .CLKOUT_EN_O(clk_en), .CMP_POWER_O(cmp_pwr), .MODE_O(mode));
	ulpi_link_end ulpi_link_end_i (.CLK_I(clk), .RST_N_I(rst_n), .U(u.link), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdata));
	ulpi_alt_mode_interface_sva ulpi_alt_mode_interface_sva_i (.CLK_I(clk), .RST_N_I(rst_n), .dir(u.dir),
		.nxt(u.nxt), .stp(u.stp), .stp_link_oe_n(u.stp_link_oe_n), .stp_pullup_en(u.stp_pullup_en),
		.data(u.data), .data_link_oe_n(u.data_link_oe_n));
	// ****************************************
	// access and compare tasks
	// ****************************************
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic phy_wr(input logic [5:0] a, input logic [7:0] d);
		int k;
		wr_reg(`LNK_CMD, {2'b00, a, d});
		k = 0;
		do begin
			rd_reg(`LNK_STAT);
			k++;
		end while (v[11] !== 1'b0 && k < 20);
		check("phy write pending", {15'h0000, v[11]}, 16'h0000);
	endtask
	task automatic wait_mode(input phy_state_t m, input string what);
		int k;
		k = 0;
		while (mode !== m && k < 400) begin
			@(posedge clk);
			k++;
		end
		#1 check(what, {13'h0000, mode}, {13'h0000, m});
	endtask
	task automatic wait_dir(input logic lvl);
		int k;
		k = 0;
		while (u.dir !== lvl && k < 200) begin
			@(posedge clk);
			k++;
		end
		#1 check("dir level", {15'h0000, u.dir}, {15'h0000, lvl});
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ****************************************
	// clock, watchdog and scenarios
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// sized well past the roughly 700 cycles the scenarios need
	initial begin
		#100000;
		fail_count++;
		finish_test();
	end
	initial begin
		rst_n = 1'b0;
		hw_rst_n = 1'b1;
		dp = 1'b1;
		dm = 1'b0;
		diff = 1'b1;
		int_src = 5'h00;
		addr = 4'h0;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
		fail_count = 0;
		n_compared = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		#1 check("stop in reset", u.stp, 1'b1);
		check("pull-up in reset", u.stp_pullup_en, 1'b0);
		wait_dir(1'b0);
		check("stop held at release", u.stp, 1'b1);
		check("pull-up at power-on", u.stp_pullup_en, 1'b1);
		wr_reg(`LNK_CTRL, 16'h0001);
		wait_mode(ST_SYNC, "start-up sync");
		check("no transmit on idle", tx_en, 1'b0);
		phy_wr(`ULPI_IFC_CTRL, 8'h80);
		check("pull-up disabled", u.stp_pullup_en, 1'b0);
		phy_wr(`ULPI_IFC_CTRL, 8'h00);
		check("pull-up enabled", u.stp_pullup_en, 1'b1);
		phy_wr(`ULPI_IE_RISE, 8'h15);
		check("comparators one mask", cmp_pwr, 2'b11);
		phy_wr(`ULPI_IE_FALL, 8'h15);
		check("comparators both masks", cmp_pwr, 2'b00);
		phy_wr(`ULPI_CARKIT_IE, 8'h00);
		phy_wr(`ULPI_CARKIT_CTRL, 8'h0C);
		foreach (TBL[i]) begin
			wr_reg(`LNK_ALT, TBL[i].alt);
			phy_wr(TBL[i].a, TBL[i].d);
			wait_mode(TBL[i].m, "mode entry");
			check("clock kept", clk_run, TBL[i].keep);
			// a running divider gives exactly two pulses in any eight cycles
			n_tick = 0;
			repeat (8) begin
				@(posedge clk);
				#1 n_tick += clk_en;
			end
			check("clock pulses", 16'(n_tick), TBL[i].keep ? 16'h0002 : 16'h0000);
			repeat (6) @(posedge clk);
			#1;
			case (TBL[i].m)
				ST_LOWPWR: check("low power bus", u.data, 8'h01);
				ST_SER3: check("three-pin bus", u.data[7:1], 7'h03);
				ST_UART: begin
					check("uart bus", u.data[7:1], {6'h00, dp});
					check("uart tx and edge", {txd_en, txd, fs_edge}, 3'h4);
				end
				default: begin
					check("six-pin bus", u.data[7:3], {1'b0, diff, dm, dp, 1'b0});
					check("serial tx", {tx_en, tx_data, serial_tx_single_zero}, 3'b101);
					@(posedge clk);
					int_src[0] <= 1'b1;
					repeat (6) @(posedge clk);
					#1 check("alt interrupt", u.data[3], 1'b1);
					@(posedge clk);
					int_src[0] <= 1'b0;
				end
			endcase
			if (TBL[i].hw) begin
				@(posedge clk);
				hw_rst_n <= 1'b0;
				repeat (4) @(posedge clk);
				#1 check("pull-up in hw reset", u.stp_pullup_en, 1'b0);
				check("mode in hw reset", {13'h0000, mode}, {13'h0000, ST_WAKE});
				@(posedge clk);
				hw_rst_n <= 1'b1;
			end
			wr_reg(`LNK_CTRL, 16'h0003);
			wait_dir(1'b0);
			wr_reg(`LNK_CTRL, 16'h0001);
			wait_mode(ST_SYNC, "exit to sync");
			wr_reg(`LNK_ALT, 16'hFF00);
			if (TBL[i].m == ST_LOWPWR) begin
				phy_wr(`ULPI_IE_RISE, 8'h1F);
				check("comparators back on", cmp_pwr, 2'b11);
			end
		end
		finish_test();
	end
endmodule // ulpi_alt_mode_interface_tb_top
